// *** logic/oam_operand_unit.v ***
// operand addressing and execute unit
`default_nettype none
`include "oam_defines.vh"
module oam_operand_unit (
	// clock and reset
	input  wire       core_clk,
	input  wire       rst_n,
	// instruction from fetch
	input  wire       instr_valid,
	input  wire [2:0] instr_mode,
	input  wire [2:0] instr_op,
	input  wire [1:0] instr_sel,
	input  wire       instr_reg_space,
	input  wire [7:0] instr_byte1,
	input  wire [7:0] instr_byte2,
	// data read answer
	input  wire [7:0] mem_rdata,
	// data access
	output reg        mem_rd,
	output reg        mem_wr,
	output reg  [7:0] mem_addr,
	output reg        mem_reg_space,
	output reg        mem_bank,
	output reg  [7:0] mem_wdata,
	// status
	output reg        busy,
	output reg        done,
	output reg  [1:0] instr_len,
	// core registers
	output reg  [7:0] acc,
	output reg  [7:0] index_x,
	output reg  [7:0] stack_pointer,
	output reg  [7:0] flags
);
	localparam ST_IDLE  = 2'h0;
	localparam ST_READ  = 2'h1;
	localparam ST_EXEC  = 2'h2;

	reg  [1:0] state_reg;
	reg  [1:0] state_next;
	reg  [2:0] op_reg;
	reg  [1:0] sel_reg;
	reg  [2:0] mode_reg;
	reg  [7:0] imm_reg;
	reg  [7:0] addr_next;
	reg  [7:0] src1;
	reg  [7:0] src2;

	wire [1:0] len_dec;
	wire       use_index;
	wire       dst_mem;
	wire       src_mem;
	wire       src_imm;
	wire [7:0] alu_result;
	wire       alu_carry;
	wire [1:0] mode_len;
	wire       m_use_index;
	wire       m_dst_mem;
	wire       m_src_mem;
	wire       m_src_imm;

	// decode for incoming instruction
	oam_mode_decode u_dec_in (
		.mode      (instr_mode),
		.len       (len_dec),
		.use_index (use_index),
		.dst_mem   (dst_mem),
		.src_mem   (src_mem),
		.src_imm   (src_imm)
	);

	// decode for instruction in flight
	oam_mode_decode u_dec_hold (
		.mode      (mode_reg),
		.len       (mode_len),
		.use_index (m_use_index),
		.dst_mem   (m_dst_mem),
		.src_mem   (m_src_mem),
		.src_imm   (m_src_imm)
	);

	// selected register value, used as second source of source modes
	function [7:0] reg_pick;
		input [1:0] sel;
		input [7:0] a;
		input [7:0] f;
		input [7:0] sp;
		input [7:0] x;
		begin
			case (sel)
				`OAM_SEL_A:  reg_pick = a;
				`OAM_SEL_F:  reg_pick = f;
				`OAM_SEL_SP: reg_pick = sp;
				default:     reg_pick = x;
			endcase
		end
	endfunction

	// 8-bit sum wraps; carry beyond bit 7 is dropped on purpose
	always @* begin
		if (use_index)
			addr_next = instr_byte1 + index_x;
		else
			addr_next = instr_byte1;
	end

	// first and second alu source per mode
	always @* begin
		src1 = imm_reg;
		src2 = reg_pick(sel_reg, acc, flags, stack_pointer, index_x);
		if (m_dst_mem) begin
			src2 = mem_rdata;
			if (m_src_imm)
				src1 = imm_reg;
			else if (mode_reg == `OAM_MODE_DST_IDX)
				src1 = acc;
			else if (sel_reg == `OAM_SEL_X)
				src1 = index_x;
			else
				src1 = acc;
		end else if (m_src_mem) begin
			src1 = mem_rdata;
		end else begin
			src1 = imm_reg;
		end
	end

	oam_alu u_alu (
		.op        (op_reg),
		.src1      (src1),
		.src2      (src2),
		.carry_in  (flags[2]),
		.result    (alu_result),
		.carry_out (alu_carry)
	);

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (instr_valid) begin
					if (src_mem || dst_mem)
						state_next = ST_READ;
					else
						state_next = ST_EXEC;
				end
			end
			ST_READ: state_next = ST_EXEC;
			ST_EXEC: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg     <= ST_IDLE;
			op_reg        <= 3'h0;
			sel_reg       <= `OAM_SEL_A;
			mode_reg      <= `OAM_MODE_SRC_IMM;
			imm_reg       <= `OAM_REG_RESET;
			mem_rd        <= 1'b0;
			mem_wr        <= 1'b0;
			mem_addr      <= `OAM_REG_RESET;
			mem_reg_space <= 1'b0;
			mem_bank      <= 1'b0;
			mem_wdata     <= `OAM_REG_RESET;
			busy          <= 1'b0;
			done          <= 1'b0;
			instr_len     <= `OAM_LEN_TWO;
			acc           <= `OAM_REG_RESET;
			index_x       <= `OAM_REG_RESET;
			stack_pointer <= `OAM_REG_RESET;
			flags         <= `OAM_F_RESET;
		end else begin
			state_reg <= state_next;
			mem_rd    <= 1'b0;
			mem_wr    <= 1'b0;
			done      <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (instr_valid) begin
						busy          <= 1'b1;
						op_reg        <= instr_op;
						sel_reg       <= instr_sel;
						mode_reg      <= instr_mode;
						instr_len     <= len_dec;
						// three byte forms carry the immediate in the third byte
						imm_reg       <= (len_dec == `OAM_LEN_THREE) ? instr_byte2 : instr_byte1;
						mem_addr      <= addr_next;
						mem_reg_space <= instr_reg_space;
						mem_bank      <= flags[`OAM_F_BANK_BIT] & instr_reg_space;
						mem_rd        <= src_mem | dst_mem;
					end
				end
				ST_EXEC: begin
					busy <= 1'b0;
					done <= 1'b1;
					if (m_dst_mem) begin
						// source register left alone in destination modes
						mem_wr    <= 1'b1;
						mem_wdata <= alu_result;
					end else begin
						case (sel_reg)
							`OAM_SEL_A:  acc <= alu_result;
							`OAM_SEL_SP: stack_pointer <= alu_result;
							`OAM_SEL_X:  index_x <= alu_result;
							default:     flags <= (flags & ~`OAM_F_WMASK) | (alu_result & `OAM_F_WMASK);
						endcase
					end
					if (op_reg != 3'h0 && !(!m_dst_mem && sel_reg == `OAM_SEL_F)) begin
						flags[2] <= alu_carry;
						flags[1] <= (alu_result == 8'h00);
					end
				end
				default: begin
					busy <= busy;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// *** inc/oam_defines.vh ***
// constants for the operand addressing block
`ifndef OAM_DEFINES_VH
`define OAM_DEFINES_VH
// addressing modes
`define OAM_MODE_SRC_IMM   3'h0
`define OAM_MODE_SRC_DIR   3'h1
`define OAM_MODE_SRC_IDX   3'h2
`define OAM_MODE_DST_DIR   3'h3
`define OAM_MODE_DST_IDX   3'h4
`define OAM_MODE_DST_DIMM  3'h5
`define OAM_MODE_DST_XIMM  3'h6
// register selects
`define OAM_SEL_A          2'h0
`define OAM_SEL_F          2'h1
`define OAM_SEL_SP         2'h2
`define OAM_SEL_X          2'h3
// flags register
`define OAM_F_BANK_BIT     4
`define OAM_F_WMASK        8'h17
`define OAM_F_RESET        8'h02
`define OAM_REG_RESET      8'h00
// instruction lengths
`define OAM_LEN_TWO        2'h2
`define OAM_LEN_THREE      2'h3
`endif

// *** logic/oam_mode_decode.v ***
// mode decode: length, source and destination kinds
`default_nettype none
`include "oam_defines.vh"
module oam_mode_decode (
	// mode in
	input  wire [2:0] mode,
	// decoded
	output reg  [1:0] len,
	output reg        use_index,
	output reg        dst_mem,
	output reg        src_mem,
	output reg        src_imm
);
	always @* begin
		len       = `OAM_LEN_TWO;
		use_index = 1'b0;
		dst_mem   = 1'b0;
		src_mem   = 1'b0;
		src_imm   = 1'b0;
		case (mode)
			`OAM_MODE_SRC_IMM: begin
				src_imm = 1'b1;
			end
			`OAM_MODE_SRC_DIR: begin
				src_mem = 1'b1;
			end
			`OAM_MODE_SRC_IDX: begin
				src_mem   = 1'b1;
				use_index = 1'b1;
			end
			`OAM_MODE_DST_DIR: begin
				dst_mem = 1'b1;
			end
			`OAM_MODE_DST_IDX: begin
				dst_mem   = 1'b1;
				use_index = 1'b1;
			end
			`OAM_MODE_DST_DIMM: begin
				dst_mem = 1'b1;
				src_imm = 1'b1;
				len     = `OAM_LEN_THREE;
			end
			`OAM_MODE_DST_XIMM: begin
				dst_mem   = 1'b1;
				src_imm   = 1'b1;
				use_index = 1'b1;
				len       = `OAM_LEN_THREE;
			end
			default: begin
				len = `OAM_LEN_TWO;
			end
		endcase
	end
endmodule
`default_nettype wire

// *** logic/oam_alu.v ***
// small alu combining first and second source
`default_nettype none
`include "oam_defines.vh"
module oam_alu (
	// operands
	input  wire [2:0] op,
	input  wire [7:0] src1,
	input  wire [7:0] src2,
	input  wire       carry_in,
	// result
	output reg  [7:0] result,
	output reg        carry_out
);
	reg [8:0] sum;
	always @* begin
		sum       = 9'h000;
		result    = src1;
		carry_out = carry_in;
		case (op)
			3'h0: result = src1;
			3'h1: begin
				sum       = {1'b0, src2} + {1'b0, src1};
				result    = sum[7:0];
				carry_out = sum[8];
			end
			3'h2: begin
				sum       = {1'b0, src2} + {1'b0, src1} + {8'h00, carry_in};
				result    = sum[7:0];
				carry_out = sum[8];
			end
			3'h3: begin
				sum       = {1'b0, src2} - {1'b0, src1};
				result    = sum[7:0];
				carry_out = sum[8];
			end
			3'h4: result = src2 & src1;
			3'h5: result = src2 | src1;
			3'h6: result = src2 ^ src1;
			default: result = src1;
		endcase
	end
endmodule
`default_nettype wire

// *** sim/oam_mem_model.sv ***
// data ram and register space model
`default_nettype none
module oam_mem_model (
	// data access
	input  wire logic       core_clk,
	input  wire logic       mem_rd,
	input  wire logic       mem_wr,
	input  wire logic [7:0] mem_addr,
	input  wire logic       mem_reg_space,
	input  wire logic       mem_bank,
	input  wire logic [7:0] mem_wdata,
	// read answer
	output var  logic [7:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:1023];
	initial begin
		for (int i = 0; i < 1024; i++)
			mem[i] = i[7:0] ^ {i[9:8], 6'h00};
		mem_rdata = 8'h00;
	end
	// idle cycles show the inverse so stale data cannot pass
	always @(posedge core_clk) begin
		mem_rdata <= mem_rd ? mem[{mem_reg_space, mem_bank, mem_addr}] : ~mem_rdata;
		if (mem_wr)
			mem[{mem_reg_space, mem_bank, mem_addr}] <= mem_wdata;
	end
endmodule
`default_nettype wire

// *** sim/oam_unit_asserts.sv ***
// port checker for the operand unit
`default_nettype none
module oam_unit_asserts (
	// clock, reset, request
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       instr_valid,
	input wire logic [2:0] instr_mode,
	input wire logic [7:0] instr_byte1,
	// answers
	input wire logic       busy,
	input wire logic       done,
	input wire logic       mem_rd,
	input wire logic       mem_wr,
	input wire logic [7:0] mem_addr,
	input wire logic       mem_reg_space,
	input wire logic       mem_bank,
	input wire logic [1:0] instr_len,
	input wire logic [7:0] acc,
	input wire logic [7:0] index_x,
	input wire logic [7:0] flags
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic       take;
	logic [2:0] mode_q;
	assign take = instr_valid && !busy;
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n) mode_q <= 3'h0;
		else if (take) mode_q <= instr_mode;
	chk_imm_done: assert property (take && instr_mode == 3'h0 |-> ##2 done) else $error("imm done");
	chk_imm_nord: assert property (take && instr_mode == 3'h0 |=> !mem_rd) else $error("imm read");
	chk_dir_addr: assert property (take && instr_mode inside {3'h1, 3'h3, 3'h5}
		|=> mem_rd && mem_addr == $past(instr_byte1)) else $error("dir addr");
	chk_idx_addr: assert property (take && instr_mode inside {3'h2, 3'h4, 3'h6}
		|=> mem_rd && mem_addr == 8'($past(instr_byte1) + $past(index_x))) else $error("idx addr");
	chk_len_match: assert property (done |-> instr_len == (mode_q > 3'h4 ? 2'h3 : 2'h2)) else $error("len");
	chk_dst_write: assert property (take && instr_mode > 3'h2 |-> ##3 mem_wr && done) else $error("dst wr");
	chk_src_keep: assert property (take && instr_mode > 3'h2
		|=> ($stable(acc) && $stable(index_x)) [*3]) else $error("src kept");
	chk_src_nowr: assert property (mem_wr |-> mode_q > 3'h2) else $error("src wr");
	chk_bank_sel: assert property (mem_rd |-> mem_bank == (mem_reg_space & flags[4])) else $error("bank");
	cov_imm: cover property (take && instr_mode == 3'h0);
	cov_idx: cover property (take && instr_mode == 3'h6);
	cov_bank: cover property (mem_rd && mem_bank);
endmodule
bind oam_operand_unit oam_unit_asserts i_chk (.core_clk, .rst_n, .instr_valid, .instr_mode, .instr_byte1, .busy,
	.done, .mem_rd, .mem_wr, .mem_addr, .mem_reg_space, .mem_bank, .instr_len, .acc, .index_x, .flags);
`default_nettype wire

// *** sim/cpu_operand_addressing_modes_tb_top.sv ***
// testbench for the operand unit
`default_nettype none
module cpu_operand_addressing_modes_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic       core_clk, rst_n, instr_valid, instr_reg_space, mem_rd, mem_wr, mem_reg_space, mem_bank, busy, done;
	logic [2:0] instr_mode, instr_op;
	logic [1:0] instr_sel, instr_len;
	logic [7:0] instr_byte1, instr_byte2, mem_rdata, mem_addr, mem_wdata, acc, index_x, stack_pointer, flags;
	int         miscompares = 0;
	int         check_count = 0;
	oam_operand_unit i_dut (.core_clk, .rst_n, .instr_valid, .instr_mode, .instr_op, .instr_sel, .instr_reg_space,
		.instr_byte1, .instr_byte2, .mem_rdata, .mem_rd, .mem_wr, .mem_addr, .mem_reg_space, .mem_bank,
		.mem_wdata, .busy, .done, .instr_len, .acc, .index_x, .stack_pointer, .flags);
	oam_mem_model i_mem (.core_clk, .mem_rd, .mem_wr, .mem_addr, .mem_reg_space, .mem_bank, .mem_wdata, .mem_rdata);
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s exp %h got %h", name, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// drive one instruction and wait for its done pulse
	task automatic run(input logic [2:0] m, input logic [2:0] o, input logic [1:0] s, input logic r,
		input logic [7:0] b1, input logic [7:0] b2);
		int n;
		{instr_mode, instr_op, instr_sel, instr_reg_space, instr_byte1, instr_byte2} = {m, o, s, r, b1, b2};
		instr_valid = 1'b1;
		@(negedge core_clk);
		instr_valid = 1'b0;
		for (n = 0; n < 20 && done !== 1'b1; n++)
			@(negedge core_clk);
		if (n == 20) begin
			miscompares++;
			finish_test();
		end
		// memory model takes the write one edge after done
		@(negedge core_clk);
	endtask
	task automatic t_src_imm();
		run(3'h0, 3'h0, 2'h0, 1'b0, 8'h3c, 8'h00);
		chk("acc", 8'h3c, acc);
		run(3'h0, 3'h1, 2'h0, 1'b0, 8'h05, 8'h00);
		chk("acc", 8'h41, acc);
		run(3'h0, 3'h0, 2'h3, 1'b0, 8'h10, 8'h00);
		chk("x", 8'h10, index_x);
		run(3'h0, 3'h0, 2'h2, 1'b0, 8'h80, 8'h00);
		chk("sp", 8'h80, stack_pointer);
		run(3'h0, 3'h0, 2'h1, 1'b0, 8'h10, 8'h00);
		chk("flags", 8'h10, flags);
	endtask
	// bank one selected: register space reads carry bit pattern c0
	task automatic t_src_mem();
		run(3'h1, 3'h0, 2'h0, 1'b1, 8'h08, 8'h00);
		chk("acc", 8'hc8, acc);
		run(3'h1, 3'h1, 2'h3, 1'b0, 8'h07, 8'h00);
		chk("x", 8'h17, index_x);
		run(3'h2, 3'h0, 2'h0, 1'b0, 8'hf5, 8'h00);
		chk("acc", 8'h0c, acc);
	endtask
	task automatic t_dst_mem();
		run(3'h3, 3'h1, 2'h0, 1'b0, 8'h07, 8'h00);
		chk("ram7", 8'h13, i_mem.mem[7]);
		run(3'h4, 3'h1, 2'h0, 1'b1, 8'he9, 8'h00);
		chk("reg300", 8'hcc, i_mem.mem[10'h300]);
		run(3'h5, 3'h1, 2'h0, 1'b0, 8'h09, 8'h05);
		chk("ram9", 8'h0e, i_mem.mem[9]);
		run(3'h6, 3'h0, 2'h0, 1'b1, 8'h03, 8'h06);
		chk("reg31a", 8'h06, i_mem.mem[10'h31a]);
		chk("acc", 8'h0c, acc);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	initial begin
		{rst_n, instr_valid, instr_mode, instr_op, instr_sel, instr_reg_space, instr_byte1, instr_byte2} = '0;
		repeat (20) @(negedge core_clk);
		rst_n = 1'b1;
		t_src_imm();
		t_src_mem();
		t_dst_mem();
		finish_test();
	end
endmodule
`default_nettype wire
